// [pcd_fault_sync.sv]
`timescale 1ns/1ps
module pcd_fault_sync
(
    // Clock and reset
    input  wire logic sys_clk_in,
    input  wire logic rst_n_in,
    // Pin and result
    input  wire logic periphery_fault_n_in,
    output logic      fault_out
);

    typedef struct packed {
        logic s1;
        logic s2;
    } pcd_sync_t;

    pcd_sync_t st_reg;
    pcd_sync_t st_next;

    // Two stages; only the second stage is looked at
    always_comb
    begin
        st_next    = st_reg;
        st_next.s1 = ~periphery_fault_n_in;     // see [RQ15]
        st_next.s2 = st_reg.s1;                 // see [RQ17]
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign fault_out = st_reg.s2;               // see [RQ16]

endmodule // pcd_fault_sync

// [pcd_periph_model.sv]
`timescale 1ns/1ps
module pcd_periph_model
(
    // Design pins, open drain
    input  wire logic [3:0] data_out_in,
    input  wire logic [3:0] data_oe_n_in,
    input  wire logic [3:0] param_out_in,
    input  wire logic [3:0] param_oe_n_in,
    // Sensor pull-downs
    input  wire logic [3:0] data_pull_in,
    input  wire logic [3:0] param_pull_in,
    // Resolved levels
    output logic      [3:0] data_level_out,
    output logic      [3:0] param_level_out
);
    // ****************************************************************
    // Wired AND with pull-ups
    // ****************************************************************
    // A released line reads high unless its sensor pulls it down, never its last driven value
    assign data_level_out  = ~((~data_oe_n_in & ~data_out_in)
                               | data_pull_in);
    assign param_level_out = ~((~param_oe_n_in & ~param_out_in)
                               | param_pull_in);
endmodule // pcd_periph_model

// [pcd_pkg.sv]
package pcd_pkg;

    // ****************************************************************
    // Configuration codes
    // ****************************************************************
    localparam logic [3:0] CODE_TURNAROUND = 4'h7;
    localparam logic [3:0] CODE_ALL_OUT    = 4'h8;
    localparam logic [3:0] CODE_DISABLED   = 4'hf;

    // ****************************************************************
    // Port modes
    // ****************************************************************
    typedef enum logic [1:0] {
        PCD_IN,
        PCD_OUT,
        PCD_BIDIR,
        PCD_OFF
    } pcd_mode_t;

    // ****************************************************************
    // Reset values and register map
    // ****************************************************************
    localparam logic [3:0]  OUT_RESET     = 4'hf;
    localparam int          SYNC_STAGES   = 2;
    localparam logic [31:0] ADDR_CONFIG   = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS   = 32'h0000_0004;
    localparam logic [31:0] ADDR_IRQ_STAT = 32'h0000_0008;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'h0000_000c;
    localparam logic [31:0] ADDR_PINS     = 32'h0000_0010;
    localparam int          CFG_CODE_LSB  = 0;
    localparam int          CFG_SAFE_BIT  = 4;
    localparam int          CFG_BIG_BIT   = 5;
    localparam int          CFG_EXT_BIT   = 6;
    localparam int          IRQ_FAULT_BIT = 0;
    localparam int          IRQ_DSTB_BIT  = 1;
    localparam int          IRQ_PSTB_BIT  = 2;
    localparam logic [6:0]  CONFIG_RESET  = 7'h00;

endpackage

// [pcd_port_config.sv]
// Functional notes
// [RQ1] Port directions come from the four-bit code, mapped differently in safety mode.
// [RQ2] An output port holds its value until the next data or parameter strobe.
// [RQ3] An input port keeps its open-drain driver released.
// [RQ4] A disabled port has no input function and keeps its driver released.
// [RQ5] The data reply returns the master's bit for every data output port.
// [RQ6] Outside code 7 parameter ports are bidirectional and read back pin levels. Here safety mode on the small package keeps them released.
// [RQ7] Normal codes 0-6 keep data port 0 input and add top outputs or bidirs.
// [RQ8] Normal codes 8-E keep data port 0 output and add top inputs or bidirs.
// [RQ9] Code 7 makes data ports outputs and turns parameter ports by call type.
// [RQ10] The configuring party never programs code 7 on the small package.
// [RQ11] Code F disables data exchange: outputs released and no reply given.
// [RQ12] Extended addressing drives the select bit on the top parameter port.
// [RQ13] Safety mode, code not 7: ports 0/2 fault-tolerant inputs, 1/3 outputs.
// [RQ14] Safety mode code 7 on the large package time-shares parameter pins.
// [RQ15] A low fault input sets the fault status bit to one.
// [RQ16] The fault input passes a clock synchroniser before the status bit.
// [RQ17] The synchroniser has two flip-flop stages on the system clock.
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module pcd_port_config
(
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hwdata_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic             irq_out,
    // Call decoder side
    input  wire logic        data_exchange_call_in,
    input  wire logic        param_write_call_in,
    input  wire logic [3:0]  call_info_in,
    input  wire logic        ext_addr_mode_in,
    output logic      [3:0]  reply_data_out,
    output logic             reply_valid_out,
    output logic      [3:0]  param_readback_out,
    output logic             fault_status_bit_out,
    output logic             data_strobe_n_out,
    output logic             param_strobe_n_out,
    // Periphery fault, active low
    input  wire logic        periphery_fault_n_in,
    // Data ports, open drain
    input  wire logic [3:0]  data_port_in,
    output logic      [3:0]  data_port_out,
    output logic      [3:0]  data_port_oe_n_out,
    // Parameter ports, open drain
    input  wire logic [3:0]  param_port_in,
    output logic      [3:0]  param_port_out,
    output logic      [3:0]  param_port_oe_n_out,
    output logic      [3:0]  safety_fault_input_out
);

    // ****************************************************************
    // Port mode decoding
    // ****************************************************************
    function automatic pcd_pkg::pcd_mode_t data_mode(
        input logic [3:0] code,
        input logic       safe,
        input logic [1:0] idx
    );
        logic [2:0] top;
        logic       hi;
        pcd_pkg::pcd_mode_t m;
        top = 3'd0;
        hi  = code[3];
        m   = pcd_pkg::PCD_IN;
        if (safe)
        begin
            if (code == pcd_pkg::CODE_TURNAROUND)
                m = pcd_pkg::PCD_OUT;                         // see [RQ14]
            else
                m = idx[0] ? pcd_pkg::PCD_OUT : pcd_pkg::PCD_IN; // see [RQ13]
        end
        else if (code == pcd_pkg::CODE_DISABLED)
            m = pcd_pkg::PCD_OFF;                             // see [RQ4]
        else if (code == pcd_pkg::CODE_TURNAROUND ||
                 code == pcd_pkg::CODE_ALL_OUT)
            m = pcd_pkg::PCD_OUT;                             // see [RQ9]
        else
        begin
            // Number of top ports that leave the base direction
            top = 3'((code[2:0] + 3'd1) >> 1);
            if ({1'b0, idx} >= 3'(3'd4 - top))
            begin
                if (!code[0])
                    m = pcd_pkg::PCD_BIDIR;                   // see [RQ7]
                else
                    m = hi ? pcd_pkg::PCD_IN : pcd_pkg::PCD_OUT; // see [RQ8]
            end
            else
                m = hi ? pcd_pkg::PCD_OUT : pcd_pkg::PCD_IN;  // see [RQ1]
        end
        return m;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [6:0]  config_r;
        logic [3:0]  data_out;
        logic [3:0]  param_out;
        logic        param_input;
        logic [3:0]  reply;
        logic        reply_valid;
        logic        sel_bit;
        logic        dstb_n;
        logic        pstb_n;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_mask;
        logic        ph_valid;
        logic        ph_write;
        logic [31:0] ph_addr;
        logic [31:0] rdata;
    } pcd_state_t;

    pcd_state_t st_reg;
    pcd_state_t st_next;

    logic              fault_sync;
    logic [3:0]        code;
    logic              safe;
    logic              big_pkg;
    logic              turn;
    pcd_pkg::pcd_mode_t dmode [4];
    logic [3:0]        d_out_mask;
    logic [3:0]        d_drive;
    logic [2:0]        events;
    logic [3:0]        reply_v;

    pcd_fault_sync u_sync
    (
        .sys_clk_in           (sys_clk_in),
        .rst_n_in             (rst_n_in),
        .periphery_fault_n_in (periphery_fault_n_in),
        .fault_out            (fault_sync)
    );

    assign code    = st_reg.config_r[pcd_pkg::CFG_CODE_LSB +: 4];
    assign safe    = st_reg.config_r[pcd_pkg::CFG_SAFE_BIT];
    assign big_pkg = st_reg.config_r[pcd_pkg::CFG_BIG_BIT];
    assign turn    = (code == pcd_pkg::CODE_TURNAROUND);

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            dmode[i]      = data_mode(code, safe, 2'(i));
            d_out_mask[i] = (dmode[i] == pcd_pkg::PCD_OUT);
            d_drive[i]    = (dmode[i] == pcd_pkg::PCD_OUT) ||
                            (dmode[i] == pcd_pkg::PCD_BIDIR);
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        st_next        = st_reg;
        st_next.dstb_n = 1'b1;
        st_next.pstb_n = 1'b1;
        st_next.reply_valid = 1'b0;
        reply_v        = '0;
        events         = '0;

        // Code F without safety: no reply, no strobe, outputs untouched
        if (data_exchange_call_in &&
            !(code == pcd_pkg::CODE_DISABLED && !safe))       // see [RQ11]
        begin
            st_next.data_out = call_info_in;                  // see [RQ2]
            // Select bit is held so the pins never follow the call bus live
            st_next.sel_bit  = call_info_in[3];               // see [RQ12]
            st_next.dstb_n   = 1'b0;
            for (int i = 0; i < 4; i++)
                reply_v[i] = d_out_mask[i] ? call_info_in[i]  // see [RQ5]
                                           : data_port_in[i];
            st_next.reply       = reply_v;
            st_next.reply_valid = 1'b1;
            events[pcd_pkg::IRQ_DSTB_BIT] = 1'b1;
            if (turn)
                st_next.param_input = 1'b1;                   // see [RQ9]
        end
        if (param_write_call_in)
        begin
            st_next.param_out   = call_info_in;               // see [RQ2]
            st_next.sel_bit     = call_info_in[3];            // see [RQ12]
            st_next.pstb_n      = 1'b0;
            st_next.param_input = 1'b0;                       // see [RQ9]
            events[pcd_pkg::IRQ_PSTB_BIT] = 1'b1;
        end
        events[pcd_pkg::IRQ_FAULT_BIT] = fault_sync;

        // Bus data phase
        if (st_reg.ph_valid && st_reg.ph_write)
        begin
            case (st_reg.ph_addr)
                pcd_pkg::ADDR_CONFIG:
                    st_next.config_r = hwdata_in[6:0];
                pcd_pkg::ADDR_IRQ_STAT:
                    st_next.irq_stat = st_reg.irq_stat & ~hwdata_in[2:0];
                pcd_pkg::ADDR_IRQ_MASK:
                    st_next.irq_mask = hwdata_in[2:0];
                default:
                    st_next.irq_mask = st_next.irq_mask;
            endcase
        end
        // Set wins over clear
        st_next.irq_stat = st_next.irq_stat | events;

        // Bus address phase
        st_next.ph_valid = 1'b0;
        if (hsel_in && hready_in && htrans_in[1])
        begin
            st_next.ph_valid = 1'b1;
            st_next.ph_write = hwrite_in;
            st_next.ph_addr  = haddr_in;
            case (haddr_in)
                pcd_pkg::ADDR_CONFIG:
                    st_next.rdata = {25'h0, st_reg.config_r};
                pcd_pkg::ADDR_STATUS:
                    st_next.rdata = {24'h0, st_reg.param_out,
                                     3'h0, fault_sync};
                pcd_pkg::ADDR_IRQ_STAT:
                    st_next.rdata = {29'h0, st_reg.irq_stat};
                pcd_pkg::ADDR_IRQ_MASK:
                    st_next.rdata = {29'h0, st_reg.irq_mask};
                pcd_pkg::ADDR_PINS:
                    st_next.rdata = {24'h0, param_port_in, data_port_in};
                default:
                    st_next.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st_reg             <= '0;
            st_reg.config_r    <= pcd_pkg::CONFIG_RESET;
            st_reg.data_out    <= pcd_pkg::OUT_RESET;
            st_reg.param_out   <= pcd_pkg::OUT_RESET;
            st_reg.sel_bit     <= 1'b1;
            st_reg.dstb_n      <= 1'b1;
            st_reg.pstb_n      <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            data_port_out[i] = st_reg.data_out[i];
            // Inputs and disabled ports never pull the pin
            data_port_oe_n_out[i] = ~d_drive[i];              // see [RQ3]
        end
        if (ext_addr_mode_in && d_drive[3])
            data_port_out[3] = st_reg.sel_bit;                // see [RQ12]
        param_port_out = st_reg.param_out;
        if (ext_addr_mode_in)
            param_port_out[3] = st_reg.sel_bit;               // see [RQ12]
        // Turnaround releases parameter pins after a data call
        param_port_oe_n_out = (turn && st_reg.param_input) ? 4'hf
                                                           : 4'h0;
        if (safe && !big_pkg && !turn)
            param_port_oe_n_out = 4'hf;                       // see [RQ13]
    end

    assign safety_fault_input_out = safe ? (turn ? param_port_in
                                                 : data_port_in)
                                         : 4'h0;              // see [RQ14]
    assign param_readback_out   = param_port_in;              // see [RQ6]
    assign reply_data_out       = st_reg.reply;               // see [RQ11]
    assign reply_valid_out      = st_reg.reply_valid;
    assign fault_status_bit_out = fault_sync;                 // see [RQ15]
    assign data_strobe_n_out    = st_reg.dstb_n;
    assign param_strobe_n_out   = st_reg.pstb_n;
    assign hrdata_out           = st_reg.rdata;
    assign hreadyout_out        = 1'b1;
    assign hresp_out            = 1'b0;
    assign irq_out              = |(st_reg.irq_stat & st_reg.irq_mask);

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_input_released: assert property (@(posedge sys_clk_in)   // see [RQ3]
        disable iff (!rst_n_in)
        (dmode[0] == pcd_pkg::PCD_IN) |-> data_port_oe_n_out[0])
        else $error("input data port 0 is driven");

    a_code_f_silent: assert property (@(posedge sys_clk_in)    // see [RQ11]
        disable iff (!rst_n_in)
        (data_exchange_call_in && !safe &&
         code == pcd_pkg::CODE_DISABLED) |=> !reply_valid_out)
        else $error("reply given with code F");

    a_reply_echo: assert property (@(posedge sys_clk_in)       // see [RQ5]
        disable iff (!rst_n_in)
        (data_exchange_call_in && !safe &&
         code == pcd_pkg::CODE_ALL_OUT) |=>
        (reply_valid_out && reply_data_out == $past(call_info_in)))
        else $error("reply does not echo output bits");

    a_data_hold: assert property (@(posedge sys_clk_in)        // see [RQ2]
        disable iff (!rst_n_in)
        !data_exchange_call_in |=> $stable(st_reg.data_out))
        else $error("data output changed without strobe");

    a_strobe_pulse: assert property (@(posedge sys_clk_in)     // see [RQ2]
        disable iff (!rst_n_in)
        (param_write_call_in) |=> (!param_strobe_n_out &&
         param_port_out[2:0] == $past(call_info_in[2:0])))
        else $error("parameter write lost");

    a_turn_input: assert property (@(posedge sys_clk_in)       // see [RQ9]
        disable iff (!rst_n_in)
        (turn && data_exchange_call_in && !param_write_call_in)
        |=> (param_port_oe_n_out == 4'hf))
        else $error("parameter ports not released on turnaround");

    a_fault_delay: assert property (@(posedge sys_clk_in)      // see [RQ16]
        disable iff (!rst_n_in)
        (!periphery_fault_n_in)[*3] |-> fault_status_bit_out)
        else $error("fault status bit late");

    a_normal_out: assert property (@(posedge sys_clk_in)       // see [RQ8]
        disable iff (!rst_n_in)
        (!safe && code == pcd_pkg::CODE_ALL_OUT) |->
        (data_port_oe_n_out == 4'h0))
        else $error("code 8 does not drive all data ports");

    a_safe_pairs: assert property (@(posedge sys_clk_in)       // see [RQ13]
        disable iff (!rst_n_in)
        (safe && !turn) |->
        (data_port_oe_n_out == 4'h5))
        else $error("safety pairs wrong");

endmodule // pcd_port_config

// [test_pcd_port_config.sv]
`timescale 1ns/1ps
module test_pcd_port_config;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic        sys_clk_in;
    logic        rst_n_in;
    logic        hsel;
    logic        hwrite;
    logic [1:0]  htrans;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic        hready;
    logic        hresp;
    logic        irq;
    logic        dx_call;
    logic        pw_call;
    logic        ext_mode;
    logic        fault_n;
    logic        fault_bit;
    logic        reply_valid;
    logic        dstb_n;
    logic        pstb_n;
    logic        seen;
    logic        stb;
    logic [3:0]  info;
    logic [3:0]  pinfo;
    logic [3:0]  sens_d;
    logic [3:0]  sens_p;
    logic [3:0]  d_lvl;
    logic [3:0]  p_lvl;
    logic [3:0]  d_out;
    logic [3:0]  d_oe_n;
    logic [3:0]  p_out;
    logic [3:0]  p_oe_n;
    logic [3:0]  reply;
    logic [3:0]  rdbk;
    logic [3:0]  sfi;
    integer      err_total;
    integer      checks;
    integer      seed;
    integer      c;
    integer      i;
    integer      m;

    pcd_port_config i_pcd_port_config
    (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hready_in(hready), .hwdata_in(hwdata),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .irq_out(irq), .data_exchange_call_in(dx_call),
        .param_write_call_in(pw_call), .call_info_in(info),
        .ext_addr_mode_in(ext_mode), .reply_data_out(reply),
        .reply_valid_out(reply_valid), .param_readback_out(rdbk),
        .fault_status_bit_out(fault_bit), .data_strobe_n_out(dstb_n),
        .param_strobe_n_out(pstb_n), .data_port_in(d_lvl),
        .data_port_out(d_out), .data_port_oe_n_out(d_oe_n),
        .param_port_in(p_lvl), .param_port_out(p_out),
        .param_port_oe_n_out(p_oe_n), .safety_fault_input_out(sfi),
        .periphery_fault_n_in(fault_n)
    );

    pcd_periph_model i_pcd_periph_model
    (
        .data_out_in(d_out), .data_oe_n_in(d_oe_n),
        .param_out_in(p_out), .param_oe_n_in(p_oe_n),
        .data_pull_in(sens_d), .param_pull_in(sens_p),
        .data_level_out(d_lvl), .param_level_out(p_lvl)
    );

    // ****************************************************************
    // Reference model and helpers
    // ****************************************************************
    // Data port mode: 0 input, 1 output, 2 bidirectional, 3 disabled
    function automatic int dmode(input int code, input int ix);
        int n;
        n = ((code % 8) + 1) / 2;
        if (code == 15)
            return 3;
        if (ix < 4 - n)
            return (code < 8) ? 0 : 1;
        if (code % 2 == 0)
            return 2;
        return (code < 8) ? 1 : 0;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Single word transfer; the wait ends only on hready
    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk_in);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge sys_clk_in); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk_in); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic do_call(input logic dx);
        int k;
        seen = 1'b0;
        stb  = 1'b0;
        @(posedge sys_clk_in);
        info    <= 4'($random(seed));
        sens_d  <= 4'($random(seed));
        sens_p  <= 4'($random(seed));
        dx_call <= dx;
        pw_call <= !dx;
        @(posedge sys_clk_in);
        dx_call <= 1'b0;
        pw_call <= 1'b0;
        for (k = 0; k < 4; k++)
        begin
            @(negedge sys_clk_in);
            seen |= (reply_valid === 1'b1);
            stb  |= ((dx ? dstb_n : pstb_n) === 1'b0);
        end
    endtask

    task finish_test;
        $display("err_total=%0d checks=%0d", err_total, checks);
        if (err_total == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ****************************************************************
    // Clock, watchdog and sequence
    // ****************************************************************
    initial
    begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end

    // The whole sequence needs well under two thousand cycles
    initial
    begin
        #(25 * 20000);
        err_total++;
        finish_test;
    end

    initial
    begin
        seed = 32'h0ebf;
        err_total = 0;
        checks = 0;
        rst_n_in = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        {dx_call, pw_call, ext_mode, info, sens_d, sens_p} = '0;
        fault_n = 1'b1;
        repeat (2) @(posedge sys_clk_in);
        chk(d_oe_n, 4'hf);
        chk(p_out, pcd_pkg::OUT_RESET);
        rst_n_in <= 1'b1;
        ahb(1'b0, pcd_pkg::ADDR_CONFIG, 32'h0, rd);
        chk(rd, 32'(pcd_pkg::CONFIG_RESET));
        chk(hresp, 1'b0);
        ahb(1'b0, 32'h0000_0020, 32'h0, rd);
        chk(rd, 32'h0);
        ahb(1'b1, pcd_pkg::ADDR_IRQ_MASK, 32'h6, rd);
        do_call(1'b1);
        chk(irq, 1'b1);
        ahb(1'b0, pcd_pkg::ADDR_IRQ_STAT, 32'h0, rd);
        chk(rd & 32'h6, 32'h2);
        ahb(1'b1, pcd_pkg::ADDR_IRQ_STAT, 32'h2, rd);
        @(negedge sys_clk_in);
        chk(irq, 1'b0);
        ahb(1'b1, pcd_pkg::ADDR_IRQ_MASK, 32'h0, rd);
        do_call(1'b0);
        chk(irq, 1'b0);
        ahb(1'b1, pcd_pkg::ADDR_IRQ_MASK, 32'h4, rd);
        @(negedge sys_clk_in);
        chk(irq, 1'b1);
        ahb(1'b1, pcd_pkg::ADDR_IRQ_STAT, 32'h4, rd);
        ahb(1'b1, pcd_pkg::ADDR_IRQ_MASK, 32'h0, rd);
        for (c = 0; c < 16; c++)
        begin
            // Code 7 only on the large package
            ahb(1'b1, pcd_pkg::ADDR_CONFIG, c | ((c == 7) ? 32'h20 : 32'h0),
                rd);
            do_call(1'b0);
            pinfo = info;
            chk(rdbk, 4'(pinfo & ~sens_p));
            do_call(1'b1);
            chk(seen, c != 15);
            chk(stb, c != 15);
            chk(4'(~p_oe_n & ~p_out),
                (c == 7) ? 4'h0 : 4'(~pinfo));
            if (c == 7)
                chk(p_oe_n, 4'hf);
            for (i = 0; i < 4; i++)
            begin
                m = dmode(c, i);
                chk(!d_oe_n[i] && !d_out[i],
                    (m == 1 || m == 2) && !info[i]);
                if (m == 0 || m == 3)
                    chk(d_oe_n[i], 1'b1);
                if (m == 1 && c != 15)
                    chk(reply[i], info[i]);
                if (m == 0)
                    chk(reply[i], !sens_d[i]);
            end
        end
        ahb(1'b1, pcd_pkg::ADDR_CONFIG, 32'h33, rd);
        do_call(1'b0);
        pinfo = info;
        do_call(1'b1);
        chk({d_oe_n[2], d_oe_n[0]}, 2'h3);
        chk(4'(~p_oe_n & ~p_out), 4'(~pinfo));
        chk(sfi, 4'(~sens_d & (info | 4'h5)));
        ahb(1'b1, pcd_pkg::ADDR_CONFIG, 32'h37, rd);
        do_call(1'b1);
        chk(4'(~d_oe_n & ~d_out), 4'(~info));
        chk(sfi, 4'(~sens_p));
        ext_mode <= 1'b1;
        for (c = 1; c < 10; c += 8)
        begin
            ahb(1'b1, pcd_pkg::ADDR_CONFIG, c, rd);
            do_call(1'b1);
            chk(!p_oe_n[3] && !p_out[3], !info[3]);
            chk(!d_oe_n[3] && !d_out[3],
                (c == 1) && !info[3]);
        end
        for (i = 0; i < 2; i++)
        begin
            @(posedge sys_clk_in);
            fault_n <= i[0];
            @(posedge sys_clk_in);
            @(negedge sys_clk_in);
            chk(fault_bit, i[0]);
            @(negedge sys_clk_in);
            chk(fault_bit, !i[0]);
        end
        finish_test;
    end
endmodule // test_pcd_port_config
